//--- testbench/pll3_divider_loop_config_properties.sv
// Assertions on the third PLL configuration store outputs.
// Assumes a bind to the top module, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module pll3_divider_loop_config_properties (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  // Bus
  input wire logic        sda_oe_o,
  // Selection and companions
  input wire logic [2:0]  copy_sel_i,
  input wire logic [pll3_cfg_pkg::NUM_COPIES-1:0] pump_msb_i,
  input wire logic [4*pll3_cfg_pkg::NUM_COPIES-1:0] fb_high_i,
  // Active settings
  input wire logic [2:0]  active_copy_o,
  input wire logic [4:0]  pump_current_o,
  input wire logic [6:0]  ref_divider_o,
  input wire logic [11:0] fb_divider_o,
  input wire logic        power_down_o,
  input wire logic        fb_divider_bad_o
);
  import pll3_cfg_pkg::*;

  logic [1:0] age_ff;
  wire logic  live = (age_ff == 2'h3);

  // Cycles since reset, saturating
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) age_ff <= 2'h0;
    else if (!live) age_ff <= age_ff + 2'h1;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  AST_RST_VAL: assert property ($fell(reset_i) |->
    ref_divider_o == 7'h03 && fb_divider_o == 12'h00c && !power_down_o)
    else $error("reset values wrong");
  AST_PD_ON: assert property (live && ref_divider_o == 7'h00 |-> power_down_o)
    else $error("zero divider without power down");
  AST_PD_OFF: assert property (power_down_o |-> ref_divider_o == 7'h00)
    else $error("power down with nonzero divider");
  AST_BAD: assert property (live |-> fb_divider_bad_o == (fb_divider_o < FB_MIN))
    else $error("feedback range flag wrong");
  AST_FB_HIGH: assert property (live |->
    fb_divider_o[11:8] == 4'($past(fb_high_i) >> (4 * active_copy_o)))
    else $error("feedback upper bits wrong");
  AST_PUMP_MSB: assert property (live |->
    pump_current_o[4] == 1'($past(pump_msb_i) >> active_copy_o))
    else $error("pump current top bit wrong");
  AST_COPY_RANGE: assert property (active_copy_o < 3'h6)
    else $error("active copy out of range");
  AST_SEL: assert property ((live && $stable(copy_sel_i))[*5] |->
    active_copy_o == (copy_sel_i > 3'h5 ? 3'h0 : copy_sel_i))
    else $error("selected copy not applied");

  cover property (power_down_o);
  cover property (active_copy_o == 3'h5);
  cover property ($rose(sda_oe_o));
endmodule // pll3_divider_loop_config_properties

`default_nettype wire

//--- testbench/pll3_divider_loop_config_test.sv
// Self-checking bench for the third PLL configuration store.
// Assumes twi_host_model and the bound property checker.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

module pll3_divider_loop_config_test;
  import pll3_cfg_pkg::*;

  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [2:0]  copy_sel_i = 3'h0;
  logic [5:0]  pump_msb_i = 6'h00;
  logic [23:0] fb_high_i = '0;
  logic        snap = 1'b0;
  wire logic   scl, sda, host_oe, dut_oe, rd_valid, pd, bad;
  wire logic [7:0]  rd_data;
  wire logic [2:0]  act;
  wire logic [4:0]  pump;
  wire logic [3:0]  res;
  wire logic [6:0]  refd;
  wire logic [11:0] fbd;
  int          err_total = 0;
  int          check_count = 0;
  logic [31:0] exp_q[$];
  logic [31:0] exp_w;
  logic [7:0]  lp[6];
  logic [7:0]  fl[6];
  logic [6:0]  rf[6];

  assign sda = !(host_oe || dut_oe);
  always #50 clk_sys_i = !clk_sys_i;

  pll3_divider_loop_config i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(dut_oe), .copy_sel_i(copy_sel_i),
    .pump_msb_i(pump_msb_i), .fb_high_i(fb_high_i), .active_copy_o(act),
    .pump_current_o(pump), .loop_resistor_o(res), .ref_divider_o(refd),
    .fb_divider_o(fbd), .power_down_o(pd), .fb_divider_bad_o(bad));

  twi_host_model i_host (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data));

  wire logic [31:0] seen = rd_valid ? {24'h00_0000, rd_data} : {act, pump, res, refd, fbd, pd};

  always @(posedge clk_sys_i) begin
    if (rd_valid || snap) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("unexpected at %0t: no expectation queued", $time);
      end else begin
        exp_w = exp_q.pop_front();
        `CHK(seen, exp_w)
      end
    end
  end

  function automatic logic [31:0] want(input int c);
    return {3'(c), pump_msb_i[c], lp[c], rf[c], fb_high_i[4*c +: 4], fl[c], rf[c] == 7'h00};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(DEV_ADDR_DEFAULT, a, d, 1'b0, 1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    i_host.xfer(DEV_ADDR_DEFAULT, a, 8'h00, 1'b1, 1);
  endtask

  task automatic look(input logic [31:0] e);
    repeat (6) @(negedge clk_sys_i);
    exp_q.push_back(e);
    snap = 1'b1;
    @(negedge clk_sys_i);
    snap = 1'b0;
  endtask

  task automatic to_reset();
    foreach (lp[i]) begin
      lp[i] = LOOP_RST;
      rf[i] = REF_RST;
      fl[i] = FB_LOW_RST;
    end
  endtask

  task automatic give_verdict();
    if (exp_q.size() != 0) err_total++;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    err_total++;
    $display("unexpected at %0t: run too long", $time);
    give_verdict();
  end

  initial begin
    void'($urandom(85));
    to_reset();
    repeat (12) @(negedge clk_sys_i);
    reset_i = 1'b0;
    look(want(0));
    for (int a = 8'h55; a <= 8'h67; a++)
      rd(8'(a), a < 8'h56 ? READ_IDLE : a < 8'h5c ? LOOP_RST :
                a < 8'h62 ? {1'b0, REF_RST} : FB_LOW_RST);
    for (int c = 0; c < 6; c++) begin
      lp[c] = 8'($urandom);
      rf[c] = 7'(1 + $urandom % 127);
      fl[c] = 8'(12 + $urandom % 244);
      wr(LOOP_OFS[c], lp[c]);
      wr(REF_OFS[c], {1'b1, rf[c]});
      wr(FB_OFS[c], fl[c]);
      rd(REF_OFS[c], {1'b0, rf[c]});
    end
    // Burst read across all reference bytes, pointer advancing per byte
    for (int c = 0; c < 6; c++) exp_q.push_back({25'h000_0000, rf[c]});
    i_host.xfer(DEV_ADDR_DEFAULT, REF_OFS[0], 8'h00, 1'b1, 6);
    pump_msb_i = 6'($urandom);
    fb_high_i = 24'($urandom);
    for (int s = 7; s >= 0; s--) begin
      copy_sel_i = 3'(s);
      look(want(s > 5 ? 0 : s));
    end
    rf[0] = 7'h00;
    wr(REF_OFS[0], 8'h00);
    look(want(0));
    lp[1] = ~lp[1];
    wr(LOOP_OFS[1], lp[1]);
    look(want(0));
    copy_sel_i = 3'h1;
    look(want(1));
    wr(RSVD_A_OFS, 8'hff);
    rd(RSVD_A_OFS, READ_IDLE);
    i_host.xfer(DEV_ADDR_DEFAULT ^ 7'h01, FB_OFS[1], 8'hf5, 1'b0, 1);
    rd(FB_OFS[1], fl[1]);
    reset_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    reset_i = 1'b0;
    to_reset();
    look(want(1));
    give_verdict();
  end
endmodule // pll3_divider_loop_config_test

bind pll3_divider_loop_config pll3_divider_loop_config_properties i_props (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sda_oe_o(sda_oe_o), .copy_sel_i(copy_sel_i),
  .pump_msb_i(pump_msb_i), .fb_high_i(fb_high_i), .active_copy_o(active_copy_o),
  .pump_current_o(pump_current_o), .ref_divider_o(ref_divider_o),
  .fb_divider_o(fb_divider_o), .power_down_o(power_down_o),
  .fb_divider_bad_o(fb_divider_bad_o));

`default_nettype wire

//--- testbench/twi_host_model.sv
// Two-wire bus host model for register writes and reads.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module twi_host_model (
  // Clock
  input  wire logic       clk_i,
  // Bus lines
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_oe_o,
  // Read result
  output logic            rd_valid_o,
  output logic      [7:0] rd_data_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Start is a=0,b=1; stop is a=1,b=0
  task automatic frame(input logic a, input logic b);
    scl_o = 1'b0;
    tick(2);
    sda_oe_o = a;
    tick(6);
    scl_o = 1'b1;
    tick(8);
    sda_oe_o = b;
    tick(8);
  endtask

  // Data moves 2 cycles after the fall so no false start or stop
  task automatic put_bit(input logic b);
    scl_o = 1'b0;
    tick(2);
    sda_oe_o = !b;
    tick(6);
    scl_o = 1'b1;
    tick(8);
  endtask

  task automatic get_bit(output logic b);
    put_bit(1'b1);
    b = sda_i;
  endtask

  task automatic put_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
  endtask

  // Reads n bytes in one burst; host acknowledges all but the last
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr,
                      input logic [7:0] d, input logic rd, input int n);
    logic [7:0] q;
    frame(1'b0, 1'b1);
    put_byte({dev, 1'b0});
    put_byte(ptr);
    if (rd) begin
      frame(1'b0, 1'b1);
      put_byte({dev, 1'b1});
      for (int k = 1; k <= n; k++) begin
        for (int i = 7; i >= 0; i--) get_bit(q[i]);
        rd_data_o = q;
        rd_valid_o = 1'b1;
        tick(1);
        rd_valid_o = 1'b0;
        put_bit(k == n);
      end
    end else begin
      put_byte(d);
    end
    frame(1'b1, 1'b0);
  endtask
endmodule // twi_host_model

`default_nettype wire

//--- verilog/bit_sync.sv
// Two-stage synchroniser for pins from outside the system clock domain.
// Assumes the bits are independent levels or change slowly together.
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      // Reset to the pin's idle level so no false edge follows reset
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule // bit_sync

`default_nettype wire

//--- verilog/cfg_copy_store.sv
// One configuration copy of the third PLL: loop byte, reference divider
// and low feedback byte. Assumes one-cycle write strobes from the bus side.
`timescale 1ns/1ps
`default_nettype none

module cfg_copy_store #(
  parameter logic [7:0] LOOP_ADDR = 8'h00,
  parameter logic [7:0] REF_ADDR  = 8'h00,
  parameter logic [7:0] FB_ADDR   = 8'h00
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // Write port
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  // Stored fields
  output logic      [7:0] loop_o,
  output logic      [6:0] ref_o,
  output logic      [7:0] fb_low_o
);
  import pll3_cfg_pkg::*;

  logic [7:0] loop_ff;
  logic [6:0] ref_ff;
  logic [7:0] fb_low_ff;
  logic [7:0] nxt_loop;
  logic [6:0] nxt_ref;
  logic [7:0] nxt_fb_low;

  always_comb begin
    nxt_loop   = loop_ff;
    nxt_ref    = ref_ff;
    nxt_fb_low = fb_low_ff;
    if (wr_en_i && wr_addr_i == LOOP_ADDR) begin
      nxt_loop = wr_data_i; // RQ6
    end
    // Top bit is reserved and dropped
    if (wr_en_i && wr_addr_i == REF_ADDR) begin
      nxt_ref = wr_data_i[6:0]; // RQ1
    end
    if (wr_en_i && wr_addr_i == FB_ADDR) begin
      nxt_fb_low = wr_data_i; // RQ5
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      loop_ff   <= LOOP_RST;
      ref_ff    <= REF_RST;
      fb_low_ff <= FB_LOW_RST;
    end else begin
      loop_ff   <= nxt_loop;
      ref_ff    <= nxt_ref;
      fb_low_ff <= nxt_fb_low;
    end
  end

  assign loop_o   = loop_ff;
  assign ref_o    = ref_ff;
  assign fb_low_o = fb_low_ff;

endmodule // cfg_copy_store

`default_nettype wire

//--- verilog/pll3_cfg_pkg.sv
// Constants for the third PLL configuration store: register offsets,
// reset values, bus state codes and the device address default.
// Assumes a single 10 MHz system clock domain.
package pll3_cfg_pkg;

  localparam int NUM_COPIES = 6;

  // Offsets indexed by configuration copy number 0..5
  localparam logic [7:0] RSVD_A_OFS = 8'h55;
  localparam logic [7:0] LOOP_OFS [NUM_COPIES] = '{8'h58, 8'h59, 8'h5a, 8'h5b, 8'h56, 8'h57};
  localparam logic [7:0] REF_OFS  [NUM_COPIES] = '{8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61};
  localparam logic [7:0] FB_OFS   [NUM_COPIES] = '{8'h64, 8'h65, 8'h66, 8'h67, 8'h62, 8'h63};

  // Reset values
  localparam logic [7:0] LOOP_RST   = 8'h00;
  localparam logic [6:0] REF_RST    = 7'h03;
  localparam logic [7:0] FB_LOW_RST = 8'h0c;
  localparam logic [7:0] READ_IDLE  = 8'h00;
  // Idle level of the bus pins, {clock, data}
  localparam logic [1:0] BUS_IDLE_RST = 2'b11;

  // Smallest legal feedback count
  localparam logic [11:0] FB_MIN = 12'h00c;

  // Bus address of this block; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h50;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_DEV   = 7'b000_0010,
    ST_PTR   = 7'b000_0100,
    ST_WDATA = 7'b000_1000,
    ST_ACK   = 7'b001_0000,
    ST_RDATA = 7'b010_0000,
    ST_RACK  = 7'b100_0000
  } bus_state_t;

endpackage

//--- verilog/pll3_divider_loop_config.sv
// Third PLL configuration store behind a two-wire bus slave, with copy
// selection driving the active divider and loop settings.
// Assumes bus pins and copy select pins are asynchronous; companion
// high-bit fields arrive from registers on the same clock.
//
// What this block does
// RQ1: Each copy holds a seven-bit reference divider; top bit reserved.
// RQ2: Active reference divider of zero powers the PLL down.
// RQ3: Feedback path divides by the full twelve-bit programmed value, 12 to 4095.
// RQ4: Host must never load feedback values zero through eleven.
// RQ5: Low feedback byte stored per copy, joined with separate upper bits.
// RQ6: Pump current is five bits; top bit comes from another register.
// RQ7: Only the selected copy drives the PLL; other copies stay stored.
`timescale 1ns/1ps
`default_nettype none

module pll3_divider_loop_config #(
  parameter logic [6:0] DEV_ADDR = pll3_cfg_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic                                clk_sys_i,
  input  wire logic                                reset_i,
  // Two-wire bus
  input  wire logic                                scl_i,
  input  wire logic                                sda_i,
  output logic                                     sda_o,
  output logic                                     sda_oe_o,
  // Copy selection and companion fields
  input  wire logic [2:0]                          copy_sel_i,
  input  wire logic [pll3_cfg_pkg::NUM_COPIES-1:0] pump_msb_i,
  input  wire logic [4*pll3_cfg_pkg::NUM_COPIES-1:0] fb_high_i,
  // Active PLL settings
  output logic      [2:0]                          active_copy_o,
  output logic      [4:0]                          pump_current_o,
  output logic      [3:0]                          loop_resistor_o,
  output logic      [6:0]                          ref_divider_o,
  output logic      [11:0]                         fb_divider_o,
  output logic                                     power_down_o,
  output logic                                     fb_divider_bad_o
);
  import pll3_cfg_pkg::*;

  // Synchronised pins
  logic [1:0] bus_s;
  logic       scl_s;
  logic       sda_s;
  logic [2:0] sel_s;

  bit_sync #(
    .WIDTH   (2),
    .RST_VAL (BUS_IDLE_RST)
  ) u_bus_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .d_i       ({scl_i, sda_i}),
    .q_o       (bus_s)
  );

  bit_sync #(
    .WIDTH (3)
  ) u_sel_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .d_i       (copy_sel_i),
    .q_o       (sel_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  // Bus slave state
  bus_state_t state_ff;
  bus_state_t after_ack_ff;
  logic       scl_q_ff;
  logic       sda_q_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic       got8_ff;
  logic       sda_oe_ff;
  logic       mack_ff;
  logic       wr_en_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] wr_data_ff;

  bus_state_t nxt_state;
  bus_state_t nxt_after_ack;
  logic [2:0] nxt_bit_cnt;
  logic [7:0] nxt_shift;
  logic [7:0] nxt_ptr;
  logic       nxt_got8;
  logic       nxt_sda_oe;
  logic       nxt_mack;
  logic       nxt_wr_en;
  logic [7:0] nxt_wr_addr;
  logic [7:0] nxt_wr_data;

  logic       start_seen;
  logic       stop_seen;
  logic       scl_rise;
  logic       scl_fall;
  logic       do_load;
  logic [7:0] rd_byte;

  // Stored copies
  logic [7:0] loop_q   [NUM_COPIES];
  logic [6:0] ref_q    [NUM_COPIES];
  logic [7:0] fb_low_q [NUM_COPIES];

  for (genvar g = 0; g < NUM_COPIES; g++) begin : g_copy
    cfg_copy_store #(
      .LOOP_ADDR (LOOP_OFS[g]),
      .REF_ADDR  (REF_OFS[g]),
      .FB_ADDR   (FB_OFS[g])
    ) u_copy (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .wr_en_i   (wr_en_ff),
      .wr_addr_i (wr_addr_ff),
      .wr_data_i (wr_data_ff),
      .loop_o    (loop_q[g]),
      .ref_o     (ref_q[g]),
      .fb_low_o  (fb_low_q[g])
    );
  end

  assign start_seen = scl_s & sda_q_ff & ~sda_s;
  assign stop_seen  = scl_s & ~sda_q_ff & sda_s;
  assign scl_rise   = scl_s & ~scl_q_ff;
  assign scl_fall   = ~scl_s & scl_q_ff;

  // Read mux; reserved and unmapped offsets read zero
  always_comb begin
    rd_byte = READ_IDLE;
    for (int c = 0; c < NUM_COPIES; c++) begin
      if (ptr_ff == LOOP_OFS[c]) begin
        rd_byte = loop_q[c];
      end
      if (ptr_ff == REF_OFS[c]) begin
        rd_byte = {1'b0, ref_q[c]}; // RQ1
      end
      if (ptr_ff == FB_OFS[c]) begin
        rd_byte = fb_low_q[c];
      end
    end
  end

  always_comb begin
    nxt_state     = state_ff;
    nxt_after_ack = after_ack_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_shift     = shift_ff;
    nxt_ptr       = ptr_ff;
    nxt_got8      = got8_ff;
    nxt_sda_oe    = sda_oe_ff;
    nxt_mack      = mack_ff;
    nxt_wr_en     = 1'b0;
    nxt_wr_addr   = wr_addr_ff;
    nxt_wr_data   = wr_data_ff;
    do_load       = 1'b0;
    if (start_seen) begin
      nxt_state   = ST_DEV;
      nxt_bit_cnt = 3'h0;
      nxt_got8    = 1'b0;
      nxt_sda_oe  = 1'b0;
    end else if (stop_seen) begin
      nxt_state  = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
        end
        ST_DEV, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            nxt_shift   = {shift_ff[6:0], sda_s};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            nxt_got8    = (bit_cnt_ff == 3'h7);
          end else if (scl_fall && got8_ff) begin
            nxt_got8   = 1'b0;
            nxt_sda_oe = 1'b1;
            nxt_state  = ST_ACK;
            if (state_ff == ST_DEV) begin
              nxt_after_ack = shift_ff[0] ? ST_RDATA : ST_PTR;
              if (shift_ff[7:1] != DEV_ADDR) begin
                nxt_state  = ST_IDLE;
                nxt_sda_oe = 1'b0;
              end
            end else if (state_ff == ST_PTR) begin
              nxt_ptr       = shift_ff;
              nxt_after_ack = ST_WDATA;
            end else begin
              nxt_wr_en     = 1'b1;
              nxt_wr_addr   = ptr_ff;
              nxt_wr_data   = shift_ff;
              nxt_ptr       = ptr_ff + 8'h01;
              nxt_after_ack = ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = 3'h0;
            if (after_ack_ff == ST_RDATA) begin
              do_load = 1'b1;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_state  = after_ack_ff;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_ff == 3'h7) begin
              nxt_sda_oe = 1'b0;
              nxt_state  = ST_RACK;
            end else begin
              nxt_shift   = {shift_ff[6:0], 1'b0};
              nxt_sda_oe  = ~shift_ff[6];
              nxt_bit_cnt = bit_cnt_ff + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nxt_mack = ~sda_s;
          end else if (scl_fall) begin
            if (mack_ff) begin
              do_load = 1'b1;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_state  = ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
    // Present next byte, most significant bit first
    if (do_load) begin
      nxt_shift   = rd_byte;
      nxt_sda_oe  = ~rd_byte[7];
      nxt_ptr     = ptr_ff + 8'h01;
      nxt_bit_cnt = 3'h0;
      nxt_state   = ST_RDATA;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_ff     <= ST_IDLE;
      after_ack_ff <= ST_IDLE;
      scl_q_ff     <= 1'b1;
      sda_q_ff     <= 1'b1;
      bit_cnt_ff   <= 3'h0;
      shift_ff     <= 8'h00;
      ptr_ff       <= 8'h00;
      got8_ff      <= 1'b0;
      sda_oe_ff    <= 1'b0;
      mack_ff      <= 1'b0;
      wr_en_ff     <= 1'b0;
      wr_addr_ff   <= 8'h00;
      wr_data_ff   <= 8'h00;
    end else begin
      state_ff     <= nxt_state;
      after_ack_ff <= nxt_after_ack;
      scl_q_ff     <= scl_s;
      sda_q_ff     <= sda_s;
      bit_cnt_ff   <= nxt_bit_cnt;
      shift_ff     <= nxt_shift;
      ptr_ff       <= nxt_ptr;
      got8_ff      <= nxt_got8;
      sda_oe_ff    <= nxt_sda_oe;
      mack_ff      <= nxt_mack;
      wr_en_ff     <= nxt_wr_en;
      wr_addr_ff   <= nxt_wr_addr;
      wr_data_ff   <= nxt_wr_data;
    end
  end

  // Active settings
  logic [2:0]  act_ff;
  logic [4:0]  pump_ff;
  logic [3:0]  resist_ff;
  logic [6:0]  ref_ff;
  logic [11:0] fb_ff;
  logic        pd_ff;
  logic        bad_ff;
  logic [2:0]  nxt_act;
  logic [4:0]  nxt_pump;
  logic [3:0]  nxt_resist;
  logic [6:0]  nxt_ref;
  logic [11:0] nxt_fb;
  logic        nxt_pd;
  logic        nxt_bad;

  always_comb begin
    // Codes beyond the last copy fall back to copy zero
    nxt_act = (sel_s < 3'(NUM_COPIES)) ? sel_s : 3'h0; // RQ7
    nxt_pump   = {pump_msb_i[nxt_act], loop_q[nxt_act][7:4]}; // RQ6
    nxt_resist = loop_q[nxt_act][3:0]; // RQ7
    nxt_ref    = ref_q[nxt_act]; // RQ7
    nxt_fb     = {fb_high_i[nxt_act*4 +: 4], fb_low_q[nxt_act]}; // RQ5
    nxt_pd     = (ref_q[nxt_act] == 7'h00); // RQ2
    nxt_bad    = (nxt_fb < FB_MIN); // RQ4
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      act_ff    <= 3'h0;
      pump_ff   <= 5'h00;
      resist_ff <= 4'h0;
      ref_ff    <= REF_RST;
      fb_ff     <= FB_MIN;
      pd_ff     <= 1'b0;
      bad_ff    <= 1'b0;
    end else begin
      act_ff    <= nxt_act;
      pump_ff   <= nxt_pump;
      resist_ff <= nxt_resist;
      ref_ff    <= nxt_ref;
      fb_ff     <= nxt_fb; // RQ3
      pd_ff     <= nxt_pd;
      bad_ff    <= nxt_bad;
    end
  end

  assign sda_o            = 1'b0;
  assign sda_oe_o         = sda_oe_ff;
  assign active_copy_o    = act_ff;
  assign pump_current_o   = pump_ff;
  assign loop_resistor_o  = resist_ff;
  assign ref_divider_o    = ref_ff;
  assign fb_divider_o     = fb_ff;
  assign power_down_o     = pd_ff;
  assign fb_divider_bad_o = bad_ff;

endmodule // pll3_divider_loop_config

`default_nettype wire
